// ### inc/ccp_pkg.sv
// Shared constants and types of the capture and PWM unit.
package ccp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Mode field codes of the unit control register.
  localparam logic [3:0] MODE_OFF        = 4'h0;
  localparam logic [3:0] MODE_CAP_FALL   = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE   = 4'h5;
  localparam logic [3:0] MODE_CAP_RISE4  = 4'h6;
  localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
  localparam logic [1:0] MODE_CAP_TOP    = 2'h1;
  localparam logic [1:0] MODE_PWM_TOP    = 2'h3;
  localparam int         MODE_TOP_MSB    = 3;
  localparam int         MODE_TOP_LSB    = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Clock sources of the capture time base timer.
  localparam logic [1:0] CAP_SRC_INSTR      = 2'h0;
  localparam logic [1:0] CAP_SRC_EXT_SYNC   = 2'h1;
  localparam logic [1:0] CAP_SRC_EXT_ASYNC  = 2'h2;
  localparam logic [1:0] CAP_SRC_SYSTEM     = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Capture event prescaler terminal counts.
  localparam logic [3:0] CAP_DIV4_LAST  = 4'h3;
  localparam logic [3:0] CAP_DIV16_LAST = 4'hf;
  localparam logic [3:0] CAP_PRESC_RST  = 4'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Period timer prescaler selections and terminal counts.
  localparam logic [1:0] PS_SEL_1   = 2'h0;
  localparam logic [1:0] PS_SEL_4   = 2'h1;
  localparam logic [1:0] PS_SEL_16  = 2'h2;
  localparam logic [5:0] PS_LAST_1  = 6'h00;
  localparam logic [5:0] PS_LAST_4  = 6'h03;
  localparam logic [5:0] PS_LAST_16 = 6'h0f;
  localparam logic [5:0] PS_LAST_64 = 6'h3f;

  ////////////////////////////////////////////////////////////////////////////
  // Instruction clock is four system clock phases.
  localparam logic [1:0] INSTR_PHASE_LAST = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and resolution base.
  localparam logic [15:0] CAP_TIMER_RST = 16'h0000;
  localparam logic [7:0]  PERIOD_RST    = 8'h00;
  localparam logic [9:0]  DUTY_RST      = 10'h000;
  localparam logic [3:0]  PWM_RES_BASE  = 4'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Operating kind decoded from the mode field.
  typedef enum logic [1:0] {
    UNIT_OFF,
    UNIT_CAPTURE,
    UNIT_PWM
  } unit_kind_e;

endpackage

// ### inc/period_timer_if.sv
// Link between the unit core and its period timer.
`timescale 1ns/10ps
`default_nettype none
interface period_timer_if;
  logic       sleep_mode;
  logic       timer_on;
  logic [1:0] prescale_sel;
  logic [7:0] period_value;
  logic       instr_tick;
  logic [7:0] count;
  logic [1:0] low2;
  logic       period_match;

  modport timer (
    input  sleep_mode,
    input  timer_on,
    input  prescale_sel,
    input  period_value,
    output instr_tick,
    output count,
    output low2,
    output period_match
  );

  modport unit (
    output sleep_mode,
    output timer_on,
    output prescale_sel,
    output period_value,
    input  instr_tick,
    input  count,
    input  low2,
    input  period_match
  );
endinterface
`default_nettype wire

// ### logic/period_timer.sv
// Instruction clock phase counter and 8-bit PWM period timer.
`timescale 1ns/10ps
`default_nettype none
module period_timer (
  input wire logic   core_clk,
  input wire logic   rst,
  period_timer_if.timer tb
);

  typedef struct packed {
    logic [1:0] phase;
    logic [5:0] presc;
    logic [7:0] count;
    logic       match;
  } timer_state_s;

  timer_state_s st_reg;
  timer_state_s st_next;
  logic [5:0]   presc_last;

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler terminal count for the selected ratio.
  always_comb begin
    case (tb.prescale_sel)
      ccp_pkg::PS_SEL_1:  presc_last = ccp_pkg::PS_LAST_1;
      ccp_pkg::PS_SEL_4:  presc_last = ccp_pkg::PS_LAST_4;
      ccp_pkg::PS_SEL_16: presc_last = ccp_pkg::PS_LAST_16;
      default:            presc_last = ccp_pkg::PS_LAST_64;
    endcase
  end

  // Sleep freezes phase, prescaler and count alike.
  assign tb.instr_tick = (st_reg.phase == ccp_pkg::INSTR_PHASE_LAST) &&
                         !tb.sleep_mode;

  ////////////////////////////////////////////////////////////////////////////
  // Advance phase each system clock outside sleep and the timer on prescaled ticks.
  always_comb begin
    st_next = st_reg;
    // A match pending at sleep entry is held so the period start is kept.
    if (!tb.sleep_mode) begin
      st_next.phase = st_reg.phase + 2'h1;
      st_next.match = 1'b0;
    end
    if (tb.timer_on && tb.instr_tick) begin
      if (st_reg.presc >= presc_last) begin
        st_next.presc = 6'h00;
        if (st_reg.count == tb.period_value) begin
          st_next.count = ccp_pkg::PERIOD_RST;
          st_next.match = 1'b1;
        end else begin
          st_next.count = st_reg.count + 8'h01;
        end
      end else begin
        st_next.presc = st_reg.presc + 6'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Two low time base bits: clock phase at 1:1, else top prescaler bits.
  always_comb begin
    case (tb.prescale_sel)
      ccp_pkg::PS_SEL_1:  tb.low2 = st_reg.phase;
      ccp_pkg::PS_SEL_4:  tb.low2 = st_reg.presc[1:0];
      ccp_pkg::PS_SEL_16: tb.low2 = st_reg.presc[3:2];
      default:            tb.low2 = st_reg.presc[5:4];
    endcase
  end

  assign tb.count        = st_reg.count;
  assign tb.period_match = st_reg.match;

endmodule
`default_nettype wire

// ### logic/capture_and_pwm_unit.sv
// Capture and PWM unit: edge capture of a 16-bit timer and 10-bit PWM.
`timescale 1ns/10ps
`default_nettype none
module capture_and_pwm_unit #(
  parameter int CAP_WIDTH = 16
) (
  input  wire logic                 core_clk,
  input  wire logic                 rst,
  input  wire logic [3:0]           unit_mode_select,
  input  wire logic [7:0]           duty_high_byte,
  input  wire logic [1:0]           duty_low_bits,
  input  wire logic [7:0]           period_value,
  input  wire logic [1:0]           period_prescale_sel,
  input  wire logic                 period_timer_on,
  input  wire logic                 capture_timer_on,
  input  wire logic [1:0]           capture_clock_source,
  input  wire logic                 capture_irq_enable,
  input  wire logic                 capture_irq_flag_clear,
  input  wire logic                 sleep_mode,
  input  wire logic                 capture_pin_in,
  input  wire logic                 ext_timer_clk_in,
  output logic                      unit_io_pin_out,
  output logic                      unit_io_pin_oe,
  output logic [CAP_WIDTH-1:0]      capture_result,
  output logic [CAP_WIDTH-1:0]      capture_timer_count,
  output logic                      capture_irq_flag,
  output logic                      capture_irq_request,
  output logic [7:0]                period_timer_count,
  output logic [3:0]                pwm_resolution
);

  ////////////////////////////////////////////////////////////////////////////
  // All state of the unit apart from the period timer.
  typedef struct packed {
    logic [2:0]           pin_sync;
    logic                 pin_level;
    logic [2:0]           ext_sync;
    logic                 ext_level;
    logic [CAP_WIDTH-1:0] cap_timer;
    logic [3:0]           cap_presc;
    logic [CAP_WIDTH-1:0] cap_result;
    logic                 flag;
    logic                 irq_req;
    logic [9:0]           duty_latch;
    logic                 pwm_out;
    logic                 pin_oe;
    logic [7:0]           period_cnt;
    logic [3:0]           pwm_res;
  } unit_state_s;

  unit_state_s           st_reg;
  unit_state_s           st_next;
  ccp_pkg::unit_kind_e   kind;
  logic                  pin_level_new;
  logic                  ext_level_new;
  logic                  pin_rise;
  logic                  pin_fall;
  logic                  ext_rise;
  logic                  timer_inc;
  logic                  cap_live;
  logic                  cap_event;
  logic [9:0]            time_base;
  logic [9:0]            duty_in;

  period_timer_if tb ();

  ////////////////////////////////////////////////////////////////////////////
  // Period timer with its instruction clock phase.
  period_timer u_period_timer (
    .core_clk (core_clk),
    .rst      (rst),
    .tb       (tb.timer)
  );

  // Timer controls pass straight to the period timer.
  assign tb.sleep_mode   = sleep_mode;
  assign tb.timer_on     = period_timer_on;
  assign tb.prescale_sel = period_prescale_sel;
  assign tb.period_value = period_value;

  // Ten-bit time base and the duty value offered for the next period.
  assign time_base = {tb.count, tb.low2};
  assign duty_in   = {duty_high_byte, duty_low_bits};

  ////////////////////////////////////////////////////////////////////////////
  // Resolution in bits: two plus the highest set bit of period plus one.
  function automatic logic [3:0] resolution_of(input logic [7:0] pr);
    logic [8:0] n;
    logic [3:0] msb;
    n   = {1'b0, pr} + 9'h001;
    msb = 4'h0;
    for (int i = 0; i < 9; i++) begin
      if (n[i]) begin
        msb = 4'(i);
      end
    end
    return ccp_pkg::PWM_RES_BASE + msb;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Decode the operating kind from the mode field.
  always_comb begin
    case (unit_mode_select[ccp_pkg::MODE_TOP_MSB:ccp_pkg::MODE_TOP_LSB])
      ccp_pkg::MODE_CAP_TOP: kind = ccp_pkg::UNIT_CAPTURE;
      ccp_pkg::MODE_PWM_TOP: kind = ccp_pkg::UNIT_PWM;
      default:               kind = ccp_pkg::UNIT_OFF;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Filtered pin levels: a change counts once stages two and three agree.
  always_comb begin
    if (st_reg.pin_sync[1] == st_reg.pin_sync[2]) begin
      pin_level_new = st_reg.pin_sync[2];
    end else begin
      pin_level_new = st_reg.pin_level;
    end
    if (st_reg.ext_sync[1] == st_reg.ext_sync[2]) begin
      ext_level_new = st_reg.ext_sync[2];
    end else begin
      ext_level_new = st_reg.ext_level;
    end
  end

  // Edges of the filtered levels.
  assign pin_rise = pin_level_new && !st_reg.pin_level;
  assign pin_fall = !pin_level_new && st_reg.pin_level;
  assign ext_rise = ext_level_new && !st_reg.ext_level;

  ////////////////////////////////////////////////////////////////////////////
  // Capture timer clock: instruction ticks stop in sleep, external runs on.
  always_comb begin
    case (capture_clock_source)
      ccp_pkg::CAP_SRC_INSTR:     timer_inc = tb.instr_tick;
      ccp_pkg::CAP_SRC_EXT_SYNC:  timer_inc = ext_rise;
      ccp_pkg::CAP_SRC_EXT_ASYNC: timer_inc = ext_rise;
      ccp_pkg::CAP_SRC_SYSTEM:    timer_inc = !sleep_mode;
      default:                    timer_inc = 1'b0;
    endcase
  end

  // Captures are honoured only in timer or synced counter mode, and in
  // sleep only when the timer keeps counting from the external clock.
  always_comb begin
    cap_live = (capture_clock_source != ccp_pkg::CAP_SRC_EXT_ASYNC) &&
               (!sleep_mode ||
                capture_clock_source == ccp_pkg::CAP_SRC_EXT_SYNC);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state of the unit.
  always_comb begin
    st_next = st_reg;
    cap_event = 1'b0;

    // Three-stage synchronisers and their filtered levels.
    st_next.pin_sync  = {st_reg.pin_sync[1:0], capture_pin_in};
    st_next.ext_sync  = {st_reg.ext_sync[1:0], ext_timer_clk_in};
    st_next.pin_level = pin_level_new;
    st_next.ext_level = ext_level_new;

    // Free-running capture time base.
    if (capture_timer_on && timer_inc) begin
      st_next.cap_timer = st_reg.cap_timer + CAP_WIDTH'(1);
    end

    // Event prescaler; a stale count past the new limit fires on the next rising edge.
    if (kind != ccp_pkg::UNIT_CAPTURE) begin
      st_next.cap_presc = ccp_pkg::CAP_PRESC_RST;
    end else if (cap_live) begin
      case (unit_mode_select)
        ccp_pkg::MODE_CAP_FALL: begin
          cap_event = pin_fall;
        end
        ccp_pkg::MODE_CAP_RISE: begin
          cap_event = pin_rise;
        end
        ccp_pkg::MODE_CAP_RISE4: begin
          if (pin_rise) begin
            if (st_reg.cap_presc >= ccp_pkg::CAP_DIV4_LAST) begin
              cap_event         = 1'b1;
              st_next.cap_presc = ccp_pkg::CAP_PRESC_RST;
            end else begin
              st_next.cap_presc = st_reg.cap_presc + 4'h1;
            end
          end
        end
        ccp_pkg::MODE_CAP_RISE16: begin
          if (pin_rise) begin
            if (st_reg.cap_presc >= ccp_pkg::CAP_DIV16_LAST) begin
              cap_event         = 1'b1;
              st_next.cap_presc = ccp_pkg::CAP_PRESC_RST;
            end else begin
              st_next.cap_presc = st_reg.cap_presc + 4'h1;
            end
          end
        end
        default: begin
          cap_event = 1'b0;
        end
      endcase
    end

    // Latch the timer and raise the flag; a new event beats the clear.
    if (capture_irq_flag_clear) begin
      st_next.flag = 1'b0;
    end
    if (cap_event) begin
      st_next.cap_result = st_reg.cap_timer;
      st_next.flag       = 1'b1;
    end
    st_next.irq_req = st_next.flag && capture_irq_enable;

    // PWM waveform; everything holds while asleep.
    if (kind == ccp_pkg::UNIT_PWM) begin
      if (!sleep_mode) begin
        if (tb.period_match) begin
          st_next.duty_latch = duty_in;
          st_next.pwm_out    = (duty_in != ccp_pkg::DUTY_RST);
        end else if (time_base == st_reg.duty_latch) begin
          // A duty beyond the period never matches, so the pin stays put.
          st_next.pwm_out = 1'b0;
        end
      end
    end else begin
      st_next.pwm_out = 1'b0;
    end
    st_next.pin_oe = (kind == ccp_pkg::UNIT_PWM);

    // Observed counters and resolution.
    st_next.period_cnt = tb.count;
    st_next.pwm_res    = resolution_of(period_value);
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; every field clears on reset.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from the state register.
  assign unit_io_pin_out     = st_reg.pwm_out;
  assign unit_io_pin_oe      = st_reg.pin_oe;
  assign capture_result      = st_reg.cap_result;
  assign capture_timer_count = st_reg.cap_timer;
  assign capture_irq_flag    = st_reg.flag;
  assign capture_irq_request = st_reg.irq_req;
  assign period_timer_count  = st_reg.period_cnt;
  assign pwm_resolution      = st_reg.pwm_res;

endmodule
`default_nettype wire

// ### test/capture_and_pwm_unit_asserts.sv
// Port-level assertions of the capture and PWM unit.
`timescale 1ns/10ps
`default_nettype none
module capture_and_pwm_unit_asserts #(
  parameter int CAP_WIDTH = 16
) (
  input wire logic                 core_clk,
  input wire logic                 rst,
  input wire logic [3:0]           unit_mode_select,
  input wire logic [7:0]           period_value,
  input wire logic [1:0]           capture_clock_source,
  input wire logic                 capture_irq_enable,
  input wire logic                 capture_irq_flag_clear,
  input wire logic                 sleep_mode,
  input wire logic                 unit_io_pin_out,
  input wire logic [CAP_WIDTH-1:0] capture_result,
  input wire logic [CAP_WIDTH-1:0] capture_timer_count,
  input wire logic                 capture_irq_flag,
  input wire logic                 capture_irq_request,
  input wire logic [7:0]           period_timer_count,
  input wire logic [3:0]           pwm_resolution
);
  ////////////////////////////////////////////////////////////////////////////
  // Decodes of the inputs that gate captures.
  logic       cap_mode;
  logic       src_async;
  logic       src_instr;
  logic [3:0] res_exp;
  assign cap_mode  = unit_mode_select[3:2] == ccp_pkg::MODE_CAP_TOP;
  assign src_async = capture_clock_source == ccp_pkg::CAP_SRC_EXT_ASYNC;
  assign src_instr = capture_clock_source == ccp_pkg::CAP_SRC_INSTR;

  // Expected resolution is two plus the highest set bit of period plus one.
  always_comb begin
    res_exp = ccp_pkg::PWM_RES_BASE;
    for (int i = 1; i < 9; i++) begin
      if ((({1'b0, period_value} + 9'h001) >> i) != 9'h000) begin
        res_exp = ccp_pkg::PWM_RES_BASE + 4'(i);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // All checks run on the system clock and are quiet in reset.
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  AST_RES_LOG: assert property (
    !$past(rst) |-> pwm_resolution == $past(res_exp))
    else $error("resolution does not follow the period value");
  AST_CAP_COPY: assert property (
    $rose(capture_irq_flag) |-> capture_result == $past(capture_timer_count))
    else $error("captured value differs from the timer");
  AST_IRQ_REQ: assert property (
    !$past(rst) |-> capture_irq_request ==
      (capture_irq_flag && $past(capture_irq_enable)))
    else $error("interrupt request does not follow flag and enable");
  AST_NO_ASYNC_CAP: assert property (
    $past(src_async) |-> $stable(capture_result))
    else $error("capture taken with the asynchronous timer source");
  AST_IDLE_NO_CAP: assert property (
    !$past(cap_mode) |-> $stable(capture_result))
    else $error("capture taken outside a capture mode");
  AST_SLEEP_HOLD: assert property (
    $past(sleep_mode, 2) && $past(sleep_mode) && $past(src_instr, 2)
      && $past(src_instr) |-> $stable(capture_timer_count))
    else $error("instruction clocked timer moved in sleep");
  AST_PWM_FREEZE: assert property (
    $past(sleep_mode, 2) && $past(sleep_mode)
      |-> $stable(unit_io_pin_out) && $stable(period_timer_count))
    else $error("pin or period timer changed in sleep");
  AST_FLAG_HOLD: assert property (
    capture_irq_flag && !capture_irq_flag_clear |=> capture_irq_flag)
    else $error("capture flag dropped without a clear");
  AST_FLAG_CLEAR: assert property (
    capture_irq_flag_clear
      |=> !capture_irq_flag || capture_result != $past(capture_result))
    else $error("capture flag survived a clear without an event");

  // Main scenarios reached.
  cover property ($rose(capture_irq_flag));
  cover property ($rose(unit_io_pin_out));
  cover property (sleep_mode && unit_io_pin_out);
endmodule

bind capture_and_pwm_unit capture_and_pwm_unit_asserts #(
  .CAP_WIDTH(CAP_WIDTH)
) i_capture_and_pwm_unit_asserts (
  .core_clk, .rst, .unit_mode_select, .period_value, .capture_clock_source,
  .capture_irq_enable, .capture_irq_flag_clear, .sleep_mode,
  .unit_io_pin_out, .capture_result, .capture_timer_count, .capture_irq_flag,
  .capture_irq_request, .period_timer_count, .pwm_resolution
);
`default_nettype wire

// ### test/sig_source.sv
// Behavioural source of capture pin edges and external timer clock pulses.
`timescale 1ns/10ps
`default_nettype none
module sig_source (
  input  wire logic core_clk,
  output logic      capture_pin_in,
  output logic      ext_timer_clk_in
);
  // Both lines rest low; the timer clock stands still between requests.
  initial begin
    capture_pin_in = 1'b0;
    ext_timer_clk_in = 1'b0;
  end

  // One pin pulse; gap cycles at each level let the filter settle.
  task automatic pulse(input int gap);
    @(posedge core_clk);
    #1 capture_pin_in = 1'b1;
    repeat (gap) @(posedge core_clk);
    #1 capture_pin_in = 1'b0;
    repeat (gap) @(posedge core_clk);
    #1;
  endtask

  // External timer clock pulses, slow enough for the synchroniser.
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge core_clk);
      #1 ext_timer_clk_in = 1'b1;
      repeat (3) @(posedge core_clk);
      #1 ext_timer_clk_in = 1'b0;
      repeat (3) @(posedge core_clk);
    end
    #1;
  endtask
endmodule
`default_nettype wire

// ### test/capture_and_pwm_unit_test.sv
// Self-checking bench of the capture and PWM unit.
`timescale 1ns/10ps
`default_nettype none
module capture_and_pwm_unit_test;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  unit_mode_select = 4'h0;
  logic [7:0]  duty_high_byte = 8'h00;
  logic [1:0]  duty_low_bits = 2'h0;
  logic [7:0]  period_value = 8'h00;
  logic [1:0]  period_prescale_sel = 2'h0;
  logic        period_timer_on = 1'b0;
  logic        capture_timer_on = 1'b1;
  logic [1:0]  capture_clock_source = ccp_pkg::CAP_SRC_EXT_SYNC;
  logic        capture_irq_enable = 1'b0;
  logic        capture_irq_flag_clear = 1'b0;
  logic        sleep_mode = 1'b0;
  logic        capture_pin_in;
  logic        ext_timer_clk_in;
  logic        unit_io_pin_out;
  logic        unit_io_pin_oe;
  logic [15:0] capture_result;
  logic [15:0] capture_timer_count;
  logic        capture_irq_flag;
  logic        capture_irq_request;
  logic [7:0]  period_timer_count;
  logic [3:0]  pwm_resolution;
  logic [15:0] last_res = 16'h0000;
  int          fails = 0;
  int          checks_done = 0;
  int          cycles = 0;
  int          cap_count = 0;
  int          p;
  int          d;
  int          per;
  int          exp_hi;
  logic [3:0]  modes [4];
  int          edges [4];

  capture_and_pwm_unit i_capture_and_pwm_unit (
    .core_clk, .rst, .unit_mode_select, .duty_high_byte, .duty_low_bits,
    .period_value, .period_prescale_sel, .period_timer_on, .capture_timer_on,
    .capture_clock_source, .capture_irq_enable, .capture_irq_flag_clear,
    .sleep_mode, .capture_pin_in, .ext_timer_clk_in, .unit_io_pin_out,
    .unit_io_pin_oe, .capture_result, .capture_timer_count, .capture_irq_flag,
    .capture_irq_request, .period_timer_count, .pwm_resolution
  );
  sig_source i_sig_source (.core_clk, .capture_pin_in, .ext_timer_clk_in);

  ////////////////////////////////////////////////////////////////////////////
  // Clock and a cycle ceiling against hangs.
  always #10 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 40000) begin
      fails++;
      final_report();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks.
  task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    if (fails == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic ticks(input int n);
    i_sig_source.tick(n);
    cap_count += n;
  endtask
  task automatic clear_flag();
    capture_irq_flag_clear = 1'b1;
    step(1);
    capture_irq_flag_clear = 1'b0;
  endtask
  // Mode changes pass through off and end with a flag clear.
  task automatic set_mode(input logic [3:0] m);
    unit_mode_select = 4'h0;
    step(2);
    unit_mode_select = m;
    step(2);
    clear_flag();
  endtask
  // Sends edges, then compares flag, result and request with the model.
  task automatic cap_try(input int n, input logic expf);
    repeat (n) i_sig_source.pulse(3 + $urandom_range(5, 0));
    step(8);
    if (expf) last_res = 16'(cap_count);
    check_val({15'h0, capture_irq_flag}, {15'h0, expf});
    check_val(capture_result, last_res);
    check_val(capture_timer_count, 16'(cap_count));
    check_val({15'h0, capture_irq_request},
              {15'h0, expf & capture_irq_enable});
    clear_flag();
  endtask
  function automatic int res_of(input int pv);
    int r;
    r = 0;
    for (int v = 4 * (pv + 1); v > 1; v = v / 2) r++;
    return r;
  endfunction
  task automatic pwm_window(input int n, input int hi_exp);
    int hi;
    hi = 0;
    repeat (2 * n) begin
      step(1);
      if (unit_io_pin_out === 1'b1) hi++;
    end
    check_val(16'(hi), 16'(2 * hi_exp));
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    void'($urandom(32'hf8822907));
    modes = '{ccp_pkg::MODE_CAP_FALL, ccp_pkg::MODE_CAP_RISE,
              ccp_pkg::MODE_CAP_RISE4, ccp_pkg::MODE_CAP_RISE16};
    edges = '{1, 1, 4, 16};
    step(12);
    rst = 1'b0;
    step(1);
    check_val({15'h0, capture_irq_flag}, 16'h0000);
    check_val(capture_result, 16'h0000);
    for (int k = 0; k < 6; k++) begin
      p = (k == 0) ? 255 : (k == 1) ? 0 : $urandom_range(255, 0);
      period_value = 8'(p);
      step(2);
      check_val(16'(pwm_resolution), 16'(res_of(p)));
    end
    for (int k = 0; k < 4; k++) begin
      set_mode(modes[k]);
      if (edges[k] > 1) cap_try(edges[k] - 1, 1'b0);
      ticks(2);
      capture_irq_enable = 1'($urandom_range(1, 0));
      cap_try(1, 1'b1);
    end
    set_mode(ccp_pkg::MODE_CAP_RISE4);
    cap_try(2, 1'b0);
    set_mode(ccp_pkg::MODE_CAP_RISE4);
    cap_try(3, 1'b0);
    cap_try(1, 1'b1);
    set_mode(ccp_pkg::MODE_CAP_RISE16);
    cap_try(5, 1'b0);
    unit_mode_select = ccp_pkg::MODE_CAP_RISE4;
    step(2);
    cap_try(1, 1'b1);
    set_mode(ccp_pkg::MODE_CAP_RISE);
    capture_clock_source = ccp_pkg::CAP_SRC_EXT_ASYNC;
    ticks(2);
    cap_try(1, 1'b0);
    capture_clock_source = ccp_pkg::CAP_SRC_EXT_SYNC;
    sleep_mode = 1'b1;
    ticks(1);
    cap_try(1, 1'b1);
    capture_clock_source = ccp_pkg::CAP_SRC_INSTR;
    step(2);
    cap_try(1, 1'b0);
    sleep_mode = 1'b0;
    // Periods never shrink between cases, so the timer never overruns.
    unit_mode_select = {ccp_pkg::MODE_PWM_TOP, 2'h0};
    period_timer_on = 1'b1;
    for (int s = 0; s < 4; s++) begin
      p = s + $urandom_range(1, 0);
      d = (s == 0) ? 0 : $urandom_range(4 * (p + 1) + 1, 1);
      period_value = 8'(p);
      period_prescale_sel = 2'(s);
      {duty_high_byte, duty_low_bits} = 10'(d);
      per = 4 * (p + 1) * (1 << (2 * s));
      exp_hi = (d >= 4 * (p + 1)) ? per : d * (1 << (2 * s));
      step(2 * per + 4);
      pwm_window(per, exp_hi);
      check_val({15'h0, unit_io_pin_oe}, 16'h0001);
      check_val({15'h0, period_timer_count <= 8'(p)}, 16'h0001);
    end
    sleep_mode = 1'b1;
    step(40);
    sleep_mode = 1'b0;
    pwm_window(per, exp_hi);
    final_report();
  end
endmodule
`default_nettype wire
